/* File: core/tec_pkg.sv */
// Package with register map, reset values and types of the timer block
// Summary of operation
// - Clearing count enable zeroes counter at once
// - Re-enable before count clock: zero on it
// - Re-enable later: zero on next count clock
// - External prescaler code counts event input edges
// - Event rate up to one eighth clock
// - Event mode enable loads zero, then counts
// - Enabling while enabled leaves count alone
// - Compare match pulses output logic and irq
// - Clear-on-match makes compare B interval timer
// - Valid event edge copies count to capture while count enable is set
// - Capture edge follows the edge mode setting
// - Running outputs move only on overflow, matches or one-shot start
// - Output mode decoder per enable, pulse, mode
// - Polarity bit inverts active level sense
// - Disabled output drives inverse of polarity
package tec_pkg;
    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_PRESCALE    = 8'h04;
    localparam logic [7:0]  OFF_COMPARE_A   = 8'h08;
    localparam logic [7:0]  OFF_COMPARE_B   = 8'h0C;
    localparam logic [7:0]  OFF_COUNT       = 8'h10;
    localparam logic [7:0]  OFF_CAPTURE     = 8'h14;
    localparam logic [7:0]  OFF_COMPARE_MODE = 8'h18;
    localparam logic [7:0]  OFF_OUTPUT_CTRL = 8'h1C;
    localparam logic [7:0]  OFF_SINGLE_PULSE = 8'h20;
    localparam logic [7:0]  OFF_EDGE_MODE   = 8'h24;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h28;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h2C;
    localparam int          CTRL_CE_BIT     = 0;
    localparam int          CMODE_CLR_BIT   = 0;
    localparam int          CMODE_WAVE_LSB  = 1;
    localparam int          OCTRL_EN0_BIT   = 0;
    localparam int          OCTRL_POL0_BIT  = 1;
    localparam int          OCTRL_EN1_BIT   = 2;
    localparam int          OCTRL_POL1_BIT  = 3;
    localparam int          SP_OS_LSB       = 0;
    localparam int          SP_START_LSB    = 2;
    localparam logic [3:0]  PRESCALE_RST    = 4'h1;
    localparam logic [3:0]  PRESCALE_EXT    = 4'hF;
    localparam logic [3:0]  PRESCALE_MAX    = 4'h8;
    localparam logic [11:0] PRESCALE_BASE   = 12'h008;
    localparam logic [2:0]  CMODE_RST       = 3'h0;
    localparam logic [3:0]  OCTRL_RST       = 4'h0;
    localparam logic [1:0]  EDGE_RST        = 2'h0;
    localparam logic [15:0] COUNT_MAX       = 16'hFFFF;
    localparam int          IRQ_MATCH_A     = 0;
    localparam int          IRQ_MATCH_B     = 1;
    localparam int          IRQ_OVERFLOW    = 2;
    localparam int          IRQ_CAPTURE     = 3;
    localparam int          EVENT_MIN_PHASE_CLK = 4;
    localparam int          EVENT_RATE_DIV  = 8;

    typedef enum logic [1:0] {
        EDGE_FALL,
        EDGE_RISE,
        EDGE_BOTH,
        EDGE_NONE
    } tec_edge_t;

    typedef enum {
        WAVE_FIXED,
        WAVE_TOGGLE,
        WAVE_PWM,
        WAVE_PPG,
        WAVE_ONESHOT
    } tec_wave_t;
endpackage

/* File: core/tec_evt_if.sv */
// Interface carrying counter events and output settings
`timescale 1ns/1ps
interface tec_evt_if;
    logic       matchA;
    logic       matchB;
    logic       overflow;
    logic       running;
    logic [1:0] start;
    logic [1:0] enable;
    logic [1:0] polarity;
    logic [1:0] singlePulse;
    logic [1:0] waveMode;
    logic       clearOnMatchB;

    modport src
    (
        output matchA, matchB, overflow, running, start, enable,
        output polarity, singlePulse, waveMode, clearOnMatchB
    );
    modport sink
    (
        input matchA, matchB, overflow, running, start, enable,
        input polarity, singlePulse, waveMode, clearOnMatchB
    );
endinterface

/* File: core/tec_edge_det.sv */
// Event input synchroniser and valid edge detector
`timescale 1ns/1ps
module tec_edge_det
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       pinIn,
    input  wire logic [1:0] edgeMode,
    output logic            edgePulse
);
    logic [2:0] sync_reg;
    logic       rise;
    logic       fall;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sync_reg <= 3'h0;
        else if (ce)
            sync_reg <= {sync_reg[1:0], pinIn};
    end

    assign rise = sync_reg[1] & ~sync_reg[2];
    assign fall = ~sync_reg[1] & sync_reg[2];

    always_comb
    begin
        case (edgeMode)
            tec_pkg::EDGE_FALL: edgePulse = ce & fall;
            tec_pkg::EDGE_RISE: edgePulse = ce & rise;
            tec_pkg::EDGE_BOTH: edgePulse = ce & (rise | fall);
            default:            edgePulse = 1'b0;
        endcase
    end
endmodule

/* File: core/tec_out_ctrl.sv */
// Output control for the two timer output pins
`timescale 1ns/1ps
module tec_out_ctrl
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic ce,
    tec_evt_if.sink   ev,
    output logic      timerOutA,
    output logic      timerOutB
);
    logic [1:0] act_reg;
    logic [1:0] pin_reg;
    logic [1:0] match;

    function automatic tec_pkg::tec_wave_t decode(input logic ch,
        input logic en, input logic os, input logic [1:0] mode,
        input logic clr);
        tec_pkg::tec_wave_t w;
        w = tec_pkg::WAVE_TOGGLE;
        if (!en)
            w = tec_pkg::WAVE_FIXED;
        else if (os)
            w = tec_pkg::WAVE_ONESHOT;
        else if (!ch)
        begin
            if ((mode == 2'b01 || mode == 2'b10) && !clr)
                w = tec_pkg::WAVE_PWM;
            else if (mode == 2'b11 && clr)
                w = tec_pkg::WAVE_PPG;
        end
        else if (mode == 2'b10)
            w = tec_pkg::WAVE_PWM;
        return w;
    endfunction

    assign match = {ev.matchB, ev.matchA};

    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_chan
            tec_pkg::tec_wave_t wave;
            assign wave = decode(1'(i), ev.enable[i], ev.singlePulse[i],
                                 ev.waveMode, ev.clearOnMatchB);

            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                    act_reg[i] <= 1'b0;
                else if (ce)
                begin
                    if (!ev.running)
                        act_reg[i] <= (wave == tec_pkg::WAVE_PWM) ||
                                      (wave == tec_pkg::WAVE_PPG);
                    else
                    begin
                        case (wave)
                            tec_pkg::WAVE_TOGGLE:
                                if (match[i])
                                    act_reg[i] <= ~act_reg[i];
                            tec_pkg::WAVE_PWM:
                                if (match[i])
                                    act_reg[i] <= 1'b0;
                                else if (ev.overflow)
                                    act_reg[i] <= 1'b1;
                            tec_pkg::WAVE_PPG:
                                if (ev.matchA)
                                    act_reg[i] <= 1'b0;
                                else if (ev.matchB || ev.overflow)
                                    act_reg[i] <= 1'b1;
                            tec_pkg::WAVE_ONESHOT:
                                if (ev.start[i])
                                    act_reg[i] <= 1'b1;
                                else if (match[i])
                                    act_reg[i] <= 1'b0;
                            default:
                                act_reg[i] <= 1'b0;
                        endcase
                    end
                end
            end

            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                    pin_reg[i] <= 1'b1;
                else if (ce)
                begin
                    case (wave)
                        tec_pkg::WAVE_FIXED:
                            pin_reg[i] <= ~ev.polarity[i];
                        tec_pkg::WAVE_PWM,
                        tec_pkg::WAVE_PPG:
                            pin_reg[i] <= act_reg[i] ^ ev.polarity[i];
                        default:
                            pin_reg[i] <= ~(act_reg[i] ^ ev.polarity[i]);
                    endcase
                end
            end
        end
    endgenerate

    assign timerOutA = pin_reg[0];
    assign timerOutB = pin_reg[1];
endmodule

/* File: core/tec_top.sv */
// Timer with event counting, compare, capture and outputs on APB
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module tec_top
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        eventCaptureInput,
    output logic             timerOutA,
    output logic             timerOutB,
    output logic             irq
);
    logic        countEnable_reg;
    logic [3:0]  prescSel_reg;
    logic [15:0] compareA_reg;
    logic [15:0] compareB_reg;
    logic [15:0] count_reg;
    logic [15:0] capture_reg;
    logic [1:0]  waveMode_reg;
    logic        clearOnMatchB_reg;
    logic [3:0]  outCtrl_reg;
    logic [1:0]  singlePulse_reg;
    logic [1:0]  start_reg;
    logic [1:0]  edgeMode_reg;
    logic [3:0]  irqStatus_reg;
    logic [3:0]  irqMask_reg;
    logic [10:0] divCnt_reg;
    logic        startPend_reg;
    logic        clrPend_reg;
    logic        stepped_reg;
    logic        overflow_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rdMux;
    logic [10:0] prescMask;
    logic        edgePulse;
    logic        countTick;
    logic        matchA;
    logic        matchB;
    logic        wrEn;
    logic        mapped;
    logic        ctrlWrite;
    logic [3:0]  irqEvents;

    tec_evt_if evIf ();

    function automatic logic isMapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= tec_pkg::OFF_IRQ_MASK);
    endfunction

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        return a == off;
    endfunction

    // APB slave: zero wait states, error on unmapped address
    assign mapped    = isMapped(paddr);
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign prdata    = prdata_reg;
    assign wrEn      = psel & penable & pwrite & mapped;
    assign ctrlWrite = wrEn & hit(paddr, tec_pkg::OFF_CTRL);

    always_comb
    begin
        rdMux = 32'h0000_0000;
        case (paddr)
            tec_pkg::OFF_CTRL:         rdMux[0] = countEnable_reg;
            tec_pkg::OFF_PRESCALE:     rdMux[3:0] = prescSel_reg;
            tec_pkg::OFF_COMPARE_A:    rdMux[15:0] = compareA_reg;
            tec_pkg::OFF_COMPARE_B:    rdMux[15:0] = compareB_reg;
            tec_pkg::OFF_COUNT:        rdMux[15:0] = count_reg;
            tec_pkg::OFF_CAPTURE:      rdMux[15:0] = capture_reg;
            tec_pkg::OFF_COMPARE_MODE:
                rdMux[2:0] = {waveMode_reg, clearOnMatchB_reg};
            tec_pkg::OFF_OUTPUT_CTRL:  rdMux[3:0] = outCtrl_reg;
            tec_pkg::OFF_SINGLE_PULSE: rdMux[1:0] = singlePulse_reg;
            tec_pkg::OFF_EDGE_MODE:    rdMux[1:0] = edgeMode_reg;
            tec_pkg::OFF_IRQ_STATUS:   rdMux[3:0] = irqStatus_reg;
            tec_pkg::OFF_IRQ_MASK:     rdMux[3:0] = irqMask_reg;
            default:                   rdMux = 32'h0000_0000;
        endcase
    end

    // Read data latched in the setup cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            prdata_reg <= 32'h0000_0000;
        else if (ce && psel && !penable && !pwrite)
            prdata_reg <= rdMux;
    end

    // Software-written configuration
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            countEnable_reg   <= 1'b0;
            prescSel_reg      <= tec_pkg::PRESCALE_RST;
            compareA_reg      <= 16'h0000;
            compareB_reg      <= 16'h0000;
            waveMode_reg      <= tec_pkg::CMODE_RST[2:1];
            clearOnMatchB_reg <= tec_pkg::CMODE_RST[0];
            outCtrl_reg       <= tec_pkg::OCTRL_RST;
            singlePulse_reg   <= 2'h0;
            edgeMode_reg      <= tec_pkg::EDGE_RST;
            irqMask_reg       <= 4'h0;
        end
        else if (ce && wrEn)
        begin
            case (paddr)
                tec_pkg::OFF_CTRL:
                    countEnable_reg <= pwdata[tec_pkg::CTRL_CE_BIT];
                tec_pkg::OFF_PRESCALE:    prescSel_reg <= pwdata[3:0];
                tec_pkg::OFF_COMPARE_A:   compareA_reg <= pwdata[15:0];
                tec_pkg::OFF_COMPARE_B:   compareB_reg <= pwdata[15:0];
                tec_pkg::OFF_COMPARE_MODE:
                begin
                    clearOnMatchB_reg <= pwdata[tec_pkg::CMODE_CLR_BIT];
                    waveMode_reg <= pwdata[tec_pkg::CMODE_WAVE_LSB +: 2];
                end
                tec_pkg::OFF_OUTPUT_CTRL: outCtrl_reg <= pwdata[3:0];
                tec_pkg::OFF_SINGLE_PULSE:
                    singlePulse_reg <= pwdata[tec_pkg::SP_OS_LSB +: 2];
                tec_pkg::OFF_EDGE_MODE:   edgeMode_reg <= pwdata[1:0];
                tec_pkg::OFF_IRQ_MASK:    irqMask_reg <= pwdata[3:0];
                default:                  ;
            endcase
        end
    end

    // Write-only one-shot start triggers, one cycle each
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            start_reg <= 2'h0;
        else if (ce)
            start_reg <= (wrEn && hit(paddr, tec_pkg::OFF_SINGLE_PULSE))
                       ? pwdata[tec_pkg::SP_START_LSB +: 2] : 2'h0;
    end

    // Prescaler: divide by 8 shl code, codes 9 to 14 as code 8, or external event edges
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            divCnt_reg <= 11'h000;
        else if (ce)
            divCnt_reg <= divCnt_reg + 11'h001;
    end

    always_comb
    begin
        logic [11:0] m;
        m = 12'h000;
        if (prescSel_reg > tec_pkg::PRESCALE_MAX)
            m = tec_pkg::PRESCALE_BASE << tec_pkg::PRESCALE_MAX;
        else
            m = tec_pkg::PRESCALE_BASE << prescSel_reg;
        prescMask = 11'(m - 12'h001);
    end

    tec_edge_det u_edge
    (
        .clock     (clock),
        .rst       (rst),
        .ce        (ce),
        .pinIn     (eventCaptureInput),
        .edgeMode  (edgeMode_reg),
        .edgePulse (edgePulse)
    );

    assign countTick = (prescSel_reg == tec_pkg::PRESCALE_EXT)
                     ? edgePulse
                     : ((divCnt_reg & prescMask) == prescMask);

    // Counter with enable, start-from-zero and clear-on-match
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count_reg     <= 16'h0000;
            startPend_reg <= 1'b0;
            clrPend_reg   <= 1'b0;
            stepped_reg   <= 1'b0;
            overflow_reg  <= 1'b0;
        end
        else if (ce)
        begin
            stepped_reg  <= 1'b0;
            overflow_reg <= 1'b0;
            if (matchB && clearOnMatchB_reg)
                clrPend_reg <= 1'b1;
            if (ctrlWrite && !pwdata[tec_pkg::CTRL_CE_BIT])
            begin
                count_reg     <= 16'h0000;
                startPend_reg <= 1'b0;
                clrPend_reg   <= 1'b0;
            end
            else if (ctrlWrite && !countEnable_reg)
                startPend_reg <= 1'b1;
            else if (countEnable_reg && countTick)
            begin
                stepped_reg <= 1'b1;
                if (startPend_reg || clrPend_reg)
                begin
                    count_reg     <= 16'h0000;
                    startPend_reg <= 1'b0;
                    clrPend_reg   <= 1'b0;
                end
                else
                begin
                    count_reg    <= count_reg + 16'h0001;
                    overflow_reg <= count_reg == tec_pkg::COUNT_MAX;
                end
            end
        end
    end

    assign matchA = countEnable_reg & stepped_reg &
                    (count_reg == compareA_reg);
    assign matchB = countEnable_reg & stepped_reg &
                    (count_reg == compareB_reg);

    // Capture on each valid edge while counting
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            capture_reg <= 16'h0000;
        else if (ce && edgePulse && countEnable_reg)
            capture_reg <= count_reg;
    end

    // Sticky status, write one to clear, set wins
    assign irqEvents[tec_pkg::IRQ_MATCH_A]  = matchA;
    assign irqEvents[tec_pkg::IRQ_MATCH_B]  = matchB;
    assign irqEvents[tec_pkg::IRQ_OVERFLOW] = overflow_reg;
    assign irqEvents[tec_pkg::IRQ_CAPTURE]  = edgePulse & countEnable_reg;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            irqStatus_reg <= 4'h0;
        else if (ce)
        begin
            if (wrEn && hit(paddr, tec_pkg::OFF_IRQ_STATUS))
                irqStatus_reg <= (irqStatus_reg & ~pwdata[3:0]) |
                                 irqEvents;
            else
                irqStatus_reg <= irqStatus_reg | irqEvents;
        end
    end

    assign irq = |(irqStatus_reg & irqMask_reg);

    // Output control wiring
    assign evIf.matchA        = matchA;
    assign evIf.matchB        = matchB;
    assign evIf.overflow      = overflow_reg;
    assign evIf.running       = countEnable_reg;
    assign evIf.start         = start_reg;
    assign evIf.enable        = {outCtrl_reg[tec_pkg::OCTRL_EN1_BIT],
                                 outCtrl_reg[tec_pkg::OCTRL_EN0_BIT]};
    assign evIf.polarity      = {outCtrl_reg[tec_pkg::OCTRL_POL1_BIT],
                                 outCtrl_reg[tec_pkg::OCTRL_POL0_BIT]};
    assign evIf.singlePulse   = singlePulse_reg;
    assign evIf.waveMode      = waveMode_reg;
    assign evIf.clearOnMatchB = clearOnMatchB_reg;

    tec_out_ctrl u_out
    (
        .clock     (clock),
        .rst       (rst),
        .ce        (ce),
        .ev        (evIf),
        .timerOutA (timerOutA),
        .timerOutB (timerOutB)
    );
endmodule

/* File: testbench/tec_chk.sv */
// Port checker of the timer block, bound to its top module
`timescale 1ns/1ps
module tec_chk
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        eventCaptureInput,
    input wire logic        timerOutA,
    input wire logic        timerOutB,
    input wire logic        irq
);
    logic       wrEn;
    logic       acc;
    logic       run_reg;
    logic [3:0] octl_reg;
    logic [3:0] mask_reg;
    logic [1:0] quiet_reg;

    assign acc  = psel && penable;
    assign wrEn = acc && pwrite && ce;

    // Shadows of the control writes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            run_reg  <= 1'b0;
            octl_reg <= 4'h0;
            mask_reg <= 4'h0;
        end
        else if (wrEn && paddr == tec_pkg::OFF_CTRL)
            run_reg <= pwdata[0];
        else if (wrEn && paddr == tec_pkg::OFF_OUTPUT_CTRL)
            octl_reg <= pwdata[3:0];
        else if (wrEn && paddr == tec_pkg::OFF_IRQ_MASK)
            mask_reg <= pwdata[3:0];
    end

    // Cycles since the output settings last changed
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            quiet_reg <= 2'h0;
        else if (wrEn && paddr inside {tec_pkg::OFF_CTRL,
                 tec_pkg::OFF_COMPARE_MODE, tec_pkg::OFF_OUTPUT_CTRL})
            quiet_reg <= 2'h0;
        else if (quiet_reg != 2'h3)
            quiet_reg <= quiet_reg + 2'h1;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_stop;
        wrEn && paddr == tec_pkg::OFF_CTRL && !pwdata[0];
    endsequence
    sequence s_count_read;
        psel && !penable && paddr == tec_pkg::OFF_COUNT ##1 acc && !pwrite;
    endsequence

    AST_CE_CLEAR:
        assert property (s_stop ##[1:2] s_count_read |-> prdata == '0)
        else $error("count not zero after stop");
    AST_OUTA_REST:
        assert property (quiet_reg == 2'h3 && (!run_reg || !octl_reg[0])
            |-> timerOutA == !octl_reg[1]) else $error("output A level");
    AST_OUTB_REST:
        assert property (quiet_reg == 2'h3 && (!run_reg || !octl_reg[2])
            |-> timerOutB == !octl_reg[3]) else $error("output B level");
    AST_OUT_HOLD:
        assert property (quiet_reg == 2'h3 && !run_reg
            |=> $stable({timerOutA, timerOutB})) else $error("output moved");
    AST_IRQ_MASKED:
        assert property (mask_reg == 4'h0 |-> !irq) else $error("masked irq");
    AST_IRQ_CLEAR:
        assert property (wrEn && paddr == tec_pkg::OFF_IRQ_STATUS
            && pwdata[3:0] == 4'hF && !run_reg && quiet_reg == 2'h3
            |=> !irq) else $error("irq after clear");
    AST_SLVERR:
        assert property (acc && (paddr > 8'h2C || paddr[1:0] != 2'h0)
            |-> pslverr && (pwrite || prdata == '0)) else $error("refusal");
    AST_WIDE:
        assert property (acc && !pwrite && paddr == tec_pkg::OFF_COUNT
            |-> pready && prdata[31:16] == 16'h0000) else $error("high half");
endmodule

bind tec_top tec_chk u_chk
(
    .clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .eventCaptureInput(eventCaptureInput), .timerOutA(timerOutA),
    .timerOutB(timerOutB), .irq(irq)
);

/* File: testbench/tec_src_model.sv */
// Pulse source standing on the event capture input
`timescale 1ns/1ps
module tec_src_model
(
    input  wire logic clock,
    output logic      pinOut
);
    initial
    begin
        pinOut = 1'b0;
    end

    // Sends n pulses; a phase never goes below four clocks
    task automatic send(input int n, input int phase);
        int ph;
        ph = (phase < 4) ? 4 : phase;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clock);
            pinOut <= 1'b1;
            repeat (ph) @(posedge clock);
            pinOut <= 1'b0;
            repeat (ph - 1) @(posedge clock);
        end
    endtask
endmodule

/* File: testbench/tec_test.sv */
// Self-checking bench of the timer block
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module tec_test;
    logic        clock;
    logic        rst     = 1'b1;
    logic        ce      = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        evIn;
    logic        timerOutA;
    logic        timerOutB;
    logic        irq;
    logic [31:0] q;
    logic        err;
    int          bad_count   = 0;
    int          check_count = 0;
    int          cycles      = 0;
    int          exp;

    tec_top u_dut
    (
        .clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .eventCaptureInput(evIn),
        .timerOutA(timerOutA), .timerOutB(timerOutB), .irq(irq)
    );
    tec_src_model u_src
    (
        .clock(clock),
        .pinOut(evIn)
    );

    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(q, e);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            stop_test();
        end
    end

    initial
    begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        `CHK({timerOutA, timerOutB, irq}, 3'h6);
        rd(tec_pkg::OFF_PRESCALE, 32'h0000_0001);
        rd(8'h30, 32'h0000_0000);
        `CHK(err, 1'b1);
        wr(tec_pkg::OFF_COMPARE_A, 32'h0000_0007);
        ce <= 1'b0;
        wr(tec_pkg::OFF_COMPARE_A, 32'h0000_0005);
        ce <= 1'b1;
        rd(tec_pkg::OFF_COMPARE_A, 32'h0000_0007);
        // Event counting at the highest input rate
        wr(tec_pkg::OFF_PRESCALE, 32'h0000_000F);
        wr(tec_pkg::OFF_EDGE_MODE, 32'h0000_0001);
        wr(tec_pkg::OFF_CTRL, 32'h0000_0001);
        u_src.send(1, 4);
        repeat (6) @(posedge clock);
        rd(tec_pkg::OFF_COUNT, 32'h0000_0000);
        exp = 0;
        for (int m = 0; m < 4; m++)
        begin
            wr(tec_pkg::OFF_EDGE_MODE, 32'(m));
            u_src.send(2, 4);
            repeat (6) @(posedge clock);
            exp += (m == 2) ? 4 : ((m == 3) ? 0 : 2);
            rd(tec_pkg::OFF_COUNT, 32'(exp));
        end
        rd(tec_pkg::OFF_CAPTURE, 32'h0000_0007);
        wr(tec_pkg::OFF_CTRL, 32'h0000_0001);
        rd(tec_pkg::OFF_COUNT, 32'h0000_0008);
        wr(tec_pkg::OFF_CTRL, 32'h0000_0000);
        rd(tec_pkg::OFF_COUNT, 32'h0000_0000);
        // Interval timing on compare B with interrupts
        wr(tec_pkg::OFF_PRESCALE, 32'h0000_0000);
        wr(tec_pkg::OFF_COMPARE_A, 32'h0000_0002);
        wr(tec_pkg::OFF_COMPARE_B, 32'h0000_0004);
        wr(tec_pkg::OFF_COMPARE_MODE, 32'h0000_0001);
        wr(tec_pkg::OFF_IRQ_STATUS, 32'h0000_000F);
        wr(tec_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        wr(tec_pkg::OFF_CTRL, 32'h0000_0001);
        for (int i = 0; i < 6; i++)
        begin
            repeat (13) @(posedge clock);
            apb(1'b0, tec_pkg::OFF_COUNT, 32'h0000_0000);
            `CHK(q <= 32'h0000_0004, 1'b1);
        end
        rd(tec_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
        `CHK(irq, 1'b1);
        wr(tec_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        @(posedge clock);
        `CHK(irq, 1'b0);
        wr(tec_pkg::OFF_CTRL, 32'h0000_0000);
        repeat (3) @(posedge clock);
        wr(tec_pkg::OFF_IRQ_MASK, 32'h0000_0003);
        wr(tec_pkg::OFF_IRQ_STATUS, 32'h0000_000F);
        @(posedge clock);
        `CHK(irq, 1'b0);
        // Restart always begins from zero
        wr(tec_pkg::OFF_CTRL, 32'h0000_0001);
        repeat (8) @(posedge clock);
        apb(1'b0, tec_pkg::OFF_COUNT, 32'h0000_0000);
        `CHK(q <= 32'h0000_0001, 1'b1);
        wr(tec_pkg::OFF_CTRL, 32'h0000_0000);
        // Output pins: fixed, stopped and toggling
        wr(tec_pkg::OFF_OUTPUT_CTRL, 32'h0000_000A);
        repeat (3) @(posedge clock);
        `CHK({timerOutA, timerOutB}, 2'h0);
        wr(tec_pkg::OFF_COMPARE_MODE, 32'h0000_0000);
        wr(tec_pkg::OFF_OUTPUT_CTRL, 32'h0000_0005);
        repeat (3) @(posedge clock);
        `CHK({timerOutA, timerOutB}, 2'h3);
        wr(tec_pkg::OFF_CTRL, 32'h0000_0001);
        repeat (60) @(posedge clock);
        `CHK({timerOutA, timerOutB}, 2'h0);
        wr(tec_pkg::OFF_CTRL, 32'h0000_0000);
        repeat (3) @(posedge clock);
        `CHK({timerOutA, timerOutB}, 2'h3);
        stop_test();
    end
endmodule
